// [shared/bdc_pkg.sv]
/*
  bdc_pkg: shared constants and carriers for the branch debug control block.
  assumes a 12-bit model-register address space and 64-bit register data.
*/
package bdc_pkg;

  // model-register locations
  localparam logic [11:0] MR_DEBUG_CTRL = 12'h1d9;
  localparam logic [11:0] MR_STACK_TOP = 12'h1da;
  localparam logic [11:0] MR_STACK4_BASE = 12'h1db;
  localparam logic [11:0] MR_SRC16_BASE = 12'h680;
  localparam logic [11:0] MR_DST16_BASE = 12'h6c0;

  // control field positions
  localparam int CTRL_REC_EN_BIT = 0;
  localparam int CTRL_STEP_BIT = 1;
  localparam int CTRL_BUS_MSG_BIT = 2;
  localparam int CTRL_LOG_STORE_BIT = 3;
  localparam int CTRL_IRQ_EN_BIT = 4;
  localparam int CTRL_SKIP_KERNEL_BIT = 5;
  localparam int CTRL_SKIP_USER_BIT = 6;
  localparam int CTRL_WIDTH = 7;
  localparam logic [6:0] CTRL_RESET = 7'h00;

  // capability query
  localparam logic [31:0] CAPQ_BASIC_LEAF = 32'h0000_0001;
  localparam int CAPQ_PRIV_LOG_BIT = 4;

  // stack variants
  localparam int STACK_DEPTH_SMALL = 4;
  localparam int STACK_DEPTH_LARGE = 16;

  // trace fifo
  localparam int TRACE_FIFO_DEPTH = 32;

  // kernel privilege level
  localparam logic [1:0] PRIV_KERNEL = 2'h0;

  typedef struct packed {
    logic skip_user_logging;
    logic skip_kernel_logging;
    logic buffer_full_irq_enable;
    logic jump_log_store;
    logic bus_message_enable;
    logic step_on_jumps;
    logic recent_jump_record_enable;
  } bdc_ctrl_t;

  typedef struct packed {
    logic [63:0] src;
    logic [63:0] dst;
    logic to_bus;
    logic to_store;
  } bdc_msg_t;

  typedef enum {
    DRN_IDLE,
    DRN_HOLD
  } bdc_drain_t;

endpackage

// [hw/bdc_fifo.sv]
/*
  bdc_fifo: synchronous fifo with valid/ready on both sides.
  assumes one clock and a synchronous active-high reset.
*/
`timescale 1ns/1ns
module bdc_fifo #(
  parameter int WIDTH = 130,
  parameter int DEPTH = 32
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // fill side
  input wire logic i_in_valid,
  input wire logic [WIDTH-1:0] i_in_data,
  output logic o_in_ready,
  // drain side
  output logic o_out_valid,
  output logic [WIDTH-1:0] o_out_data,
  input wire logic i_out_ready
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0] wr_ptr_r;
  logic [AW-1:0] rd_ptr_r;
  logic [AW:0] count_r;
  logic push;
  logic pop;

  assign push = i_in_valid && o_in_ready;
  assign pop = o_out_valid && i_out_ready;
  assign o_in_ready = (count_r != (AW+1)'(DEPTH));
  assign o_out_valid = (count_r != '0);
  assign o_out_data = mem_r[rd_ptr_r];

  // storage
  always_ff @(posedge i_clk) begin
    if (push) begin
      mem_r[wr_ptr_r] <= i_in_data;
    end
  end

  // pointers and fill count
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r <= '0;
    end else begin
      if (push) begin
        wr_ptr_r <= (wr_ptr_r == AW'(DEPTH-1)) ? '0 : wr_ptr_r + 1'b1;
      end
      if (pop) begin
        rd_ptr_r <= (rd_ptr_r == AW'(DEPTH-1)) ? '0 : rd_ptr_r + 1'b1;
      end
      if (push && !pop) begin
        count_r <= count_r + 1'b1;
      end else if (pop && !push) begin
        count_r <= count_r - 1'b1;
      end
    end
  end
endmodule // bdc_fifo

// [hw/bdc_top.sv]
/*
  bdc_top: branch debug control with recent-jump stack, control register,
  single-step on jumps, bus messages and memory log requests.
  assumes the core presents one control transfer per request, model-register
  accesses one at a time, and a sink that drains trace words with valid/ready.
*/
`timescale 1ns/1ns
module bdc_top #(
  parameter int STACK_DEPTH = bdc_pkg::STACK_DEPTH_LARGE,
  parameter int FIFO_DEPTH = bdc_pkg::TRACE_FIFO_DEPTH
) (
  // clock and reset
  input wire logic I_CORE_CLK,
  input wire logic I_RST,
  // model-register access
  input wire logic I_MR_WR,
  input wire logic I_MR_RD,
  input wire logic [11:0] I_MR_ADDR,
  input wire logic [63:0] I_MR_WDATA,
  input wire logic [1:0] I_PRIVILEGE_LEVEL,
  input wire logic I_REAL_MODE,
  output logic O_MR_ACK,
  output logic O_MR_FAULT,
  output logic [63:0] O_MR_RDATA,
  // capability query
  input wire logic I_CAPQ_REQ,
  input wire logic [31:0] I_CAPQ_LEAF,
  output logic O_CAPQ_ACK,
  output logic [31:0] O_CAPQ_EXT_FEATURES,
  // control transfers from the core
  input wire logic I_XFER_VALID,
  input wire logic [63:0] I_XFER_SRC,
  input wire logic [63:0] I_XFER_DST,
  input wire logic [1:0] I_XFER_PRIV,
  input wire logic I_INSTR_RETIRE,
  input wire logic I_SINGLE_STEP_FLAG,
  input wire logic I_DEBUG_EXC,
  output logic O_XFER_READY,
  output logic O_STEP_TRAP,
  // control state
  output logic [6:0] O_CTRL,
  // trace sink: bus messages and log requests
  output logic O_TRACE_VALID,
  output logic [63:0] O_TRACE_SRC,
  output logic [63:0] O_TRACE_DST,
  output logic O_TRACE_TO_BUS,
  output logic O_TRACE_TO_STORE,
  output logic O_TRACE_WRAP,
  input wire logic I_TRACE_READY,
  input wire logic I_BUF_FULL,
  output logic O_BUF_FULL_IRQ
);
  localparam int IW = $clog2(STACK_DEPTH);
  localparam int MW = $bits(bdc_pkg::bdc_msg_t);

  bdc_pkg::bdc_ctrl_t ctrl_r;
  logic [IW-1:0] stack_top_index_r;
  logic [63:0] src_mem_r [STACK_DEPTH];
  logic [63:0] dst_mem_r [STACK_DEPTH];
  logic [IW-1:0] top_nxt;
  logic xfer_take;
  logic stack_update;
  logic store_ok;
  logic priv_ok;
  logic ctrl_hit;
  logic top_hit;
  logic src_hit;
  logic dst_hit;
  logic small_hit;
  logic [IW-1:0] src_idx;
  logic [IW-1:0] dst_idx;
  logic [IW-1:0] small_idx;
  logic [11:0] src_off;
  logic [11:0] dst_off;
  logic [11:0] small_off;
  bdc_pkg::bdc_msg_t push_msg;
  bdc_pkg::bdc_msg_t pop_msg;
  logic push_valid;
  logic push_ready;
  logic pop_valid;
  logic pop_ready;
  bdc_pkg::bdc_drain_t drain_r;

  // transfer acceptance
  assign push_valid = I_XFER_VALID && (ctrl_r.bus_message_enable || ctrl_r.jump_log_store);
  assign xfer_take = I_XFER_VALID && (push_ready || !push_valid);
  assign stack_update = xfer_take && (ctrl_r.recent_jump_record_enable || ctrl_r.bus_message_enable);

  // privilege filter for memory logging
  assign store_ok = ((I_XFER_PRIV == bdc_pkg::PRIV_KERNEL) && !ctrl_r.skip_kernel_logging)
    || ((I_XFER_PRIV != bdc_pkg::PRIV_KERNEL) && !ctrl_r.skip_user_logging);
  assign push_msg.src = I_XFER_SRC;
  assign push_msg.dst = I_XFER_DST;
  assign push_msg.to_bus = ctrl_r.bus_message_enable;
  assign push_msg.to_store = ctrl_r.jump_log_store && store_ok;

  // stack index advance
  assign top_nxt = (stack_top_index_r == IW'(STACK_DEPTH-1)) ? '0 : stack_top_index_r + 1'b1;

  // address decode
  assign priv_ok = (I_PRIVILEGE_LEVEL == bdc_pkg::PRIV_KERNEL) || I_REAL_MODE;
  assign ctrl_hit = (I_MR_ADDR == bdc_pkg::MR_DEBUG_CTRL);
  assign top_hit = (I_MR_ADDR == bdc_pkg::MR_STACK_TOP);
  assign src_off = I_MR_ADDR - bdc_pkg::MR_SRC16_BASE;
  assign dst_off = I_MR_ADDR - bdc_pkg::MR_DST16_BASE;
  assign small_off = I_MR_ADDR - bdc_pkg::MR_STACK4_BASE;
  assign src_idx = src_off[IW-1:0];
  assign dst_idx = dst_off[IW-1:0];
  assign small_idx = small_off[IW-1:0];
  assign src_hit = (STACK_DEPTH == bdc_pkg::STACK_DEPTH_LARGE)
    && (I_MR_ADDR >= bdc_pkg::MR_SRC16_BASE) && (src_off < 12'(STACK_DEPTH));
  assign dst_hit = (STACK_DEPTH == bdc_pkg::STACK_DEPTH_LARGE)
    && (I_MR_ADDR >= bdc_pkg::MR_DST16_BASE) && (dst_off < 12'(STACK_DEPTH));
  assign small_hit = (STACK_DEPTH == bdc_pkg::STACK_DEPTH_SMALL)
    && (I_MR_ADDR >= bdc_pkg::MR_STACK4_BASE) && (small_off < 12'(STACK_DEPTH));

  // control register
  always_ff @(posedge I_CORE_CLK) begin
    if (I_RST) begin
      ctrl_r <= bdc_pkg::bdc_ctrl_t'(bdc_pkg::CTRL_RESET);
    end else begin
      if (I_MR_WR && ctrl_hit && priv_ok) begin
        ctrl_r <= bdc_pkg::bdc_ctrl_t'(I_MR_WDATA[bdc_pkg::CTRL_WIDTH-1:0]);
      end
      if (I_DEBUG_EXC) begin
        ctrl_r.recent_jump_record_enable <= 1'b0;
        ctrl_r.step_on_jumps <= 1'b0;
      end
    end
  end

  // stack index
  always_ff @(posedge I_CORE_CLK) begin
    if (I_RST) begin
      stack_top_index_r <= '0;
    end else if (stack_update) begin
      stack_top_index_r <= top_nxt;
    end
  end

  // stack entries
  always_ff @(posedge I_CORE_CLK) begin
    if (stack_update) begin
      src_mem_r[top_nxt] <= I_XFER_SRC;
      dst_mem_r[top_nxt] <= I_XFER_DST;
    end
  end

  // model-register read and write answer
  always_ff @(posedge I_CORE_CLK) begin
    if (I_RST) begin
      O_MR_ACK <= 1'b0;
      O_MR_FAULT <= 1'b0;
      O_MR_RDATA <= 64'h0;
    end else begin
      O_MR_ACK <= I_MR_RD || I_MR_WR;
      O_MR_FAULT <= 1'b0;
      O_MR_RDATA <= 64'h0;
      if (I_MR_WR) begin
        O_MR_FAULT <= !(ctrl_hit && priv_ok);
      end else if (I_MR_RD) begin
        if (ctrl_hit) begin
          O_MR_RDATA <= {57'h0, ctrl_r};
        end else if (top_hit) begin
          O_MR_RDATA <= 64'(stack_top_index_r);
        end else if (src_hit) begin
          O_MR_RDATA <= src_mem_r[src_idx];
        end else if (dst_hit) begin
          O_MR_RDATA <= dst_mem_r[dst_idx];
        end else if (small_hit) begin
          O_MR_RDATA <= {dst_mem_r[small_idx][31:0], src_mem_r[small_idx][31:0]};
        end else begin
          O_MR_FAULT <= 1'b1;
        end
      end
    end
  end

  // capability query answer
  always_ff @(posedge I_CORE_CLK) begin
    if (I_RST) begin
      O_CAPQ_ACK <= 1'b0;
      O_CAPQ_EXT_FEATURES <= 32'h0;
    end else begin
      O_CAPQ_ACK <= I_CAPQ_REQ;
      O_CAPQ_EXT_FEATURES <= 32'h0;
      if (I_CAPQ_REQ && (I_CAPQ_LEAF == bdc_pkg::CAPQ_BASIC_LEAF)) begin
        O_CAPQ_EXT_FEATURES[bdc_pkg::CAPQ_PRIV_LOG_BIT] <= 1'b1;
      end
    end
  end

  // single-step trap request
  always_ff @(posedge I_CORE_CLK) begin
    if (I_RST) begin
      O_STEP_TRAP <= 1'b0;
    end else if (ctrl_r.step_on_jumps) begin
      O_STEP_TRAP <= I_SINGLE_STEP_FLAG && xfer_take && !I_DEBUG_EXC;
    end else begin
      O_STEP_TRAP <= I_SINGLE_STEP_FLAG && I_INSTR_RETIRE && !I_DEBUG_EXC;
    end
  end

  // control and back-pressure outputs
  always_ff @(posedge I_CORE_CLK) begin
    if (I_RST) begin
      O_CTRL <= bdc_pkg::CTRL_RESET;
      O_XFER_READY <= 1'b0;
    end else begin
      O_CTRL <= ctrl_r;
      O_XFER_READY <= push_ready;
    end
  end

  // trace fifo
  bdc_fifo #(
    .WIDTH(MW),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .i_clk(I_CORE_CLK),
    .i_rst(I_RST),
    .i_in_valid(push_valid),
    .i_in_data(push_msg),
    .o_in_ready(push_ready),
    .o_out_valid(pop_valid),
    .o_out_data(pop_msg),
    .i_out_ready(pop_ready)
  );

  assign pop_ready = (drain_r == bdc_pkg::DRN_IDLE);

  // trace output stage
  always_ff @(posedge I_CORE_CLK) begin
    if (I_RST) begin
      drain_r <= bdc_pkg::DRN_IDLE;
      O_TRACE_VALID <= 1'b0;
      O_TRACE_SRC <= 64'h0;
      O_TRACE_DST <= 64'h0;
      O_TRACE_TO_BUS <= 1'b0;
      O_TRACE_TO_STORE <= 1'b0;
      O_TRACE_WRAP <= 1'b0;
      O_BUF_FULL_IRQ <= 1'b0;
    end else begin
      O_BUF_FULL_IRQ <= 1'b0;
      case (drain_r)
        bdc_pkg::DRN_IDLE: begin
          if (pop_valid) begin
            O_TRACE_VALID <= 1'b1;
            O_TRACE_SRC <= pop_msg.src;
            O_TRACE_DST <= pop_msg.dst;
            O_TRACE_TO_BUS <= pop_msg.to_bus;
            if (pop_msg.to_store && I_BUF_FULL && ctrl_r.buffer_full_irq_enable) begin
              O_TRACE_TO_STORE <= 1'b0;
              O_TRACE_WRAP <= 1'b0;
              O_BUF_FULL_IRQ <= 1'b1;
            end else begin
              O_TRACE_TO_STORE <= pop_msg.to_store;
              O_TRACE_WRAP <= pop_msg.to_store && I_BUF_FULL;
            end
            drain_r <= bdc_pkg::DRN_HOLD;
          end
        end
        bdc_pkg::DRN_HOLD: begin
          if (I_TRACE_READY) begin
            O_TRACE_VALID <= 1'b0;
            O_TRACE_TO_BUS <= 1'b0;
            O_TRACE_TO_STORE <= 1'b0;
            O_TRACE_WRAP <= 1'b0;
            drain_r <= bdc_pkg::DRN_IDLE;
          end
        end
        default: begin
          drain_r <= bdc_pkg::DRN_IDLE;
        end
      endcase
    end
  end
endmodule // bdc_top

// [sim/bdc_top_sva.sv]
/* bdc_top_sva: port assertions for bdc_top.
   assumes bdc_pkg is compiled first. */
`timescale 1ns/1ns
module bdc_top_sva (
  // watched ports
  input wire logic I_CORE_CLK,
  input wire logic I_RST,
  input wire logic I_MR_WR,
  input wire logic I_MR_RD,
  input wire logic [11:0] I_MR_ADDR,
  input wire logic [63:0] I_MR_WDATA,
  input wire logic [1:0] I_PRIVILEGE_LEVEL,
  input wire logic I_REAL_MODE,
  input wire logic O_MR_ACK,
  input wire logic O_MR_FAULT,
  input wire logic [63:0] O_MR_RDATA,
  input wire logic I_CAPQ_REQ,
  input wire logic [31:0] I_CAPQ_LEAF,
  input wire logic [31:0] O_CAPQ_EXT_FEATURES,
  input wire logic I_DEBUG_EXC,
  input wire logic [6:0] O_CTRL,
  input wire logic O_TRACE_VALID,
  input wire logic [63:0] O_TRACE_SRC,
  input wire logic I_TRACE_READY
);
  default clocking @(posedge I_CORE_CLK); endclocking
  default disable iff (I_RST);
  logic cw;
  logic lf1;
  logic [6:0] wd;
  assign cw = I_MR_WR && I_MR_ADDR == bdc_pkg::MR_DEBUG_CTRL;
  assign lf1 = I_CAPQ_LEAF == bdc_pkg::CAPQ_BASIC_LEAF;
  assign wd = I_MR_WDATA[6:0];
  property p_ack; I_MR_WR || I_MR_RD |=> O_MR_ACK; endproperty
  a_ack: assert property (p_ack) else $error("no ack");
  property p_wr; cw && (I_PRIVILEGE_LEVEL == 2'h0 || I_REAL_MODE) && !I_DEBUG_EXC
    |-> ##2 O_CTRL == $past(wd, 2); endproperty
  a_wr: assert property (p_wr) else $error("ctrl write lost");
  property p_flt; cw && I_PRIVILEGE_LEVEL != 2'h0 && !I_REAL_MODE |=> O_MR_FAULT; endproperty
  a_flt: assert property (p_flt) else $error("write not refused");
  property p_cap; I_CAPQ_REQ |=> O_CAPQ_EXT_FEATURES == ($past(lf1) ? 32'h10 : 32'h0); endproperty
  a_cap: assert property (p_cap) else $error("bad feature word");
  property p_dbg; I_DEBUG_EXC |-> ##2 O_CTRL[1:0] == 2'h0; endproperty
  a_dbg: assert property (p_dbg) else $error("enable kept");
  property p_rst; $fell(I_RST) |-> O_CTRL == 7'h00 && !O_TRACE_VALID; endproperty
  a_rst: assert property (p_rst) else $error("not reset");
  property p_hold; O_TRACE_VALID && !I_TRACE_READY |=> O_TRACE_VALID && $stable(O_TRACE_SRC); endproperty
  a_hold: assert property (p_hold) else $error("word dropped");
  property p_flr; O_MR_ACK && O_MR_FAULT |-> O_MR_RDATA == 64'h0; endproperty
  a_flr: assert property (p_flr) else $error("data on fault");
  c_flt: cover property (O_MR_ACK && O_MR_FAULT);
  c_tr: cover property (O_TRACE_VALID && I_TRACE_READY);
  c_dbg: cover property (I_DEBUG_EXC);
endmodule // bdc_top_sva
bind bdc_top bdc_top_sva sva_u (.*);

// [sim/bdc_sink_model.sv]
/* bdc_sink_model: bus monitor taking trace words.
   assumes the bench drives stall and buffer-full. */
`timescale 1ns/1ns
module bdc_sink_model (
  // controls
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_stall,
  input wire logic i_full,
  // to the block
  output logic o_ready,
  output logic o_buf_full
);
  logic [2:0] cnt_r;
  // mixes prompt and slow acceptance, none while stalled
  always_ff @(posedge i_clk) begin
    cnt_r <= i_rst ? 3'h0 : cnt_r + 3'h1;
    o_ready <= !i_rst && !i_stall && (cnt_r[2] || cnt_r[0]);
    o_buf_full <= i_full;
  end
endmodule // bdc_sink_model

// [sim/bdc_top_bench.sv]
/* bdc_top_bench: self-checking bench for bdc_top.
   assumes checker and sink model are compiled first. */
`timescale 1ns/1ns
module bdc_top_bench;
  localparam logic [11:0] CR = bdc_pkg::MR_DEBUG_CTRL;
  logic clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, rm = 1'b0, cq = 1'b0, xv = 1'b0, ret = 1'b0;
  logic tf = 1'b0, dx = 1'b0, stall = 1'b0, full = 1'b0, ewrap = 1'b0, refused = 1'b0;
  logic rdy, bf, ack, flt, trap, tv, tb, ts, tw, irq, xr, cqa;
  logic [11:0] adr = 12'h0;
  logic [1:0] pl = 2'h0, xp = 2'h0;
  logic [6:0] cv = 7'h0, ctrl;
  logic [6:0] tbl [5] = '{7'h0c, 7'h2c, 7'h4c, 7'h04, 7'h08};
  logic [31:0] leaf = 32'h0, feat;
  logic [63:0] wd = 64'h0, src = 64'h0, dst = 64'h0, lf = 64'h5f, ls, ld, ps, rdat, tsrc, tdst;
  logic [63:0] rdat4;
  int error_cnt = 0, comparisons = 0, cyc = 0, irqs = 0, eirqs = 0;
  bdc_pkg::bdc_msg_t q[$];
  bdc_pkg::bdc_msg_t m;
  bdc_top dut_u (.I_CORE_CLK(clk), .I_RST(rst), .I_MR_WR(wr), .I_MR_RD(rd), .I_MR_ADDR(adr),
    .I_MR_WDATA(wd), .I_PRIVILEGE_LEVEL(pl), .I_REAL_MODE(rm), .O_MR_ACK(ack), .O_MR_FAULT(flt),
    .O_MR_RDATA(rdat), .I_CAPQ_REQ(cq), .I_CAPQ_LEAF(leaf), .O_CAPQ_ACK(cqa), .O_CAPQ_EXT_FEATURES(feat),
    .I_XFER_VALID(xv), .I_XFER_SRC(src), .I_XFER_DST(dst), .I_XFER_PRIV(xp), .I_INSTR_RETIRE(ret),
    .I_SINGLE_STEP_FLAG(tf), .I_DEBUG_EXC(dx), .O_XFER_READY(xr), .O_STEP_TRAP(trap), .O_CTRL(ctrl),
    .O_TRACE_VALID(tv), .O_TRACE_SRC(tsrc), .O_TRACE_DST(tdst), .O_TRACE_TO_BUS(tb),
    .O_TRACE_TO_STORE(ts), .O_TRACE_WRAP(tw), .I_TRACE_READY(rdy), .I_BUF_FULL(bf), .O_BUF_FULL_IRQ(irq));
  bdc_sink_model model_u (.i_clk(clk), .i_rst(rst), .i_stall(stall), .i_full(full), .o_ready(rdy),
    .o_buf_full(bf));
  // four-entry variant shadowing the same stimulus
  bdc_top #(.STACK_DEPTH(bdc_pkg::STACK_DEPTH_SMALL)) dut4_u (.I_CORE_CLK(clk), .I_RST(rst), .I_MR_WR(wr),
    .I_MR_RD(rd), .I_MR_ADDR(adr), .I_MR_WDATA(wd), .I_PRIVILEGE_LEVEL(pl), .I_REAL_MODE(rm), .O_MR_ACK(),
    .O_MR_FAULT(), .O_MR_RDATA(rdat4), .I_CAPQ_REQ(cq), .I_CAPQ_LEAF(leaf), .O_CAPQ_ACK(),
    .O_CAPQ_EXT_FEATURES(), .I_XFER_VALID(xv), .I_XFER_SRC(src), .I_XFER_DST(dst), .I_XFER_PRIV(xp),
    .I_INSTR_RETIRE(ret), .I_SINGLE_STEP_FLAG(tf), .I_DEBUG_EXC(dx), .O_XFER_READY(), .O_STEP_TRAP(),
    .O_CTRL(), .O_TRACE_VALID(), .O_TRACE_SRC(), .O_TRACE_DST(), .O_TRACE_TO_BUS(), .O_TRACE_TO_STORE(),
    .O_TRACE_WRAP(), .I_TRACE_READY(rdy), .I_BUF_FULL(bf), .O_BUF_FULL_IRQ());
  function automatic logic [63:0] nx(logic [63:0] s);
    return {s[62:0], s[63] ^ s[62] ^ s[60] ^ s[59]};
  endfunction
  task automatic chk(string n, logic [129:0] s, logic [129:0] e);
    comparisons++;
    if (s !== e) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic finish_test();
    $display("comparisons %0d errors %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic mr(logic w, logic [11:0] a, logic [63:0] d, logic f, logic [63:0] r);
    @(posedge clk);
    wr <= w;
    rd <= !w;
    adr <= a;
    wd <= d;
    @(posedge clk);
    wr <= 1'b0;
    rd <= 1'b0;
    #1;
    chk("mr", {ack, flt, rdat}, {1'b1, f, r});
  endtask
  task automatic wctl(logic [6:0] c);
    mr(1'b1, CR, {57'h0, c}, 1'b0, 64'h0);
    cv = c;
  endtask
  task automatic cap(logic [31:0] l, logic [31:0] e);
    @(posedge clk);
    cq <= 1'b1;
    leaf <= l;
    @(posedge clk);
    cq <= 1'b0;
    #1;
    chk("capq", {cqa, feat}, {1'b1, e});
  endtask
  task automatic pulse(logic d, logic r, logic e);
    @(posedge clk);
    dx <= d;
    ret <= r;
    @(posedge clk);
    dx <= 1'b0;
    ret <= 1'b0;
    #1;
    chk("trap", trap, e);
  endtask
  task automatic send(logic e);
    bdc_pkg::bdc_msg_t n;
    logic [1:0] p;
    logic tk;
    lf = nx(lf);
    p = lf[1:0];
    n.src = lf;
    lf = nx(lf);
    n.dst = lf;
    n.to_bus = cv[2];
    n.to_store = cv[3] && !(p == 2'h0 && cv[5]) && !(p != 2'h0 && cv[6]) && !(full && cv[4]);
    if (cv[2] || cv[3]) q.push_back(n);
    ls = n.src;
    ld = n.dst;
    tk = 1'b0;
    while (!tk) begin
      @(posedge clk);
      xv <= 1'b1;
      src <= n.src;
      dst <= n.dst;
      xp <= p;
      @(posedge clk);
      xv <= 1'b0;
      #1;
      tk = xr || !(cv[2] || cv[3]);
      if (!tk) begin
        refused = 1'b1;
        stall <= 1'b0;
      end
    end
    chk("trap", trap, e);
  endtask
  task automatic drain();
    while (q.size() != 0) @(posedge clk);
    repeat (3) @(posedge clk);
  endtask
  initial begin
    forever #20 clk = ~clk;
  end
  // oldest note against each accepted trace word
  always @(posedge clk) begin
    cyc++;
    if (irq) irqs++;
    if (tv && rdy) begin
      m = q.pop_front();
      chk("trace", {tsrc, tdst, tb, ts}, m);
      if (m.to_store) chk("wrap", tw, ewrap);
    end
    if (cyc > 30000) begin
      error_cnt++;
      finish_test();
    end
  end
  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1;
    chk("ctrl", ctrl, 7'h00);
    mr(1'b0, CR, 64'h0, 1'b0, 64'h0);
    cap(32'h1, 32'h10);
    cap(32'h0, 32'h0);
    pl <= 2'h3;
    mr(1'b1, CR, 64'h7f, 1'b1, 64'h0);
    rm <= 1'b1;
    wctl(7'h03);
    rm <= 1'b0;
    pl <= 2'h0;
    mr(1'b0, CR, 64'h0, 1'b0, 64'h3);
    mr(1'b1, bdc_pkg::MR_STACK_TOP, 64'h1, 1'b1, 64'h0);
    mr(1'b0, 12'h100, 64'h0, 1'b1, 64'h0);
    wctl(7'h07);
    pulse(1'b1, 1'b0, 1'b0);
    mr(1'b0, CR, 64'h0, 1'b0, 64'h4);
    wctl(7'h02);
    tf <= 1'b1;
    send(1'b1);
    pulse(1'b0, 1'b1, 1'b0);
    wctl(7'h00);
    pulse(1'b0, 1'b1, 1'b1);
    tf <= 1'b0;
    wctl(7'h01);
    for (int k = 0; k < 17; k++) begin
      send(1'b0);
      if (k == 15) ps = ls;
    end
    mr(1'b0, bdc_pkg::MR_STACK_TOP, 64'h0, 1'b0, 64'h1);
    chk("top4", rdat4, 64'h1);
    mr(1'b0, bdc_pkg::MR_STACK4_BASE + 12'h1, 64'h0, 1'b1, 64'h0);
    chk("stack4", rdat4, {ld[31:0], ls[31:0]});
    mr(1'b0, bdc_pkg::MR_SRC16_BASE + 12'h1, 64'h0, 1'b0, ls);
    mr(1'b0, bdc_pkg::MR_DST16_BASE + 12'h1, 64'h0, 1'b0, ld);
    mr(1'b0, bdc_pkg::MR_SRC16_BASE, 64'h0, 1'b0, ps);
    mr(1'b1, bdc_pkg::MR_SRC16_BASE, 64'h0, 1'b1, 64'h0);
    foreach (tbl[i]) begin
      wctl(tbl[i]);
      repeat (6) send(1'b0);
      drain();
    end
    full <= 1'b1;
    ewrap = 1'b1;
    wctl(7'h0c);
    repeat (4) send(1'b0);
    drain();
    wctl(7'h1c);
    eirqs = 4;
    repeat (4) send(1'b0);
    drain();
    full <= 1'b0;
    chk("irqs", irqs, eirqs);
    stall <= 1'b1;
    wctl(7'h04);
    repeat (40) send(1'b0);
    chk("refused", refused, 1'b1);
    drain();
    finish_test();
  end
endmodule // bdc_top_bench
